// File: logic/xfer_pkg.sv
// Constants shared by the accumulator transfer decoder.
package xfer_pkg;
    // ----------------------------------------
    // Instruction encodings
    // ----------------------------------------
    localparam logic [9:0] OP_LOAD_DISPLAY_TIMER = 10'h20D;
    localparam logic [9:0] OP_LOAD_CLOCK_CTRL = 10'h216;
    localparam logic [9:0] OP_LOAD_TIMER_CTRL_BIT = 10'h02_AA;
    // Upper six opcode bits of the store-and-flip word; the low four bits carry j.
    localparam logic [5:0] OP_STORE_FLIP_HI = 6'h2_B;
    localparam int STORE_FLIP_J_LSB = 0;
    // ----------------------------------------
    // Register map, byte addresses
    // ----------------------------------------
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_CTRL = 4'h4;
    localparam logic [3:0] OFS_COUNT = 4'h8;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int ST_FILE_LSB = 0;
    localparam int ST_CLOCK_LSB = 4;
    localparam int ST_TIMER_BIT = 8;
    localparam int ST_DISPLAY_LSB = 12;
    localparam int ST_RELOAD_LSB = 16;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic RST_ENABLE = 1'b1;
endpackage : xfer_pkg

// File: logic/accumulator_transfer_decode.sv
// Decoder and executor for four accumulator transfer instructions.
`timescale 1ns/10ps
`default_nettype none
module accumulator_transfer_decode #(
    parameter int DP_W = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Instruction from fetch stage
    input wire logic instr_valid,
    input wire logic [9:0] instr,
    input wire logic [3:0] acc,
    input wire logic [DP_W-1:0] data_pointer,
    // RAM write port
    output logic ram_we,
    output logic [DP_W+3:0] ram_addr,
    output logic [3:0] ram_wdata,
    // Core registers
    output logic [3:0] file_reg,
    output logic [3:0] display_timer,
    output logic [3:0] display_timer_reload,
    output logic [3:0] clock_control_reg,
    output logic timer_ctrl_bit,
    // Core flag effects
    output logic done,
    output logic carry_we,
    output logic skip_next,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import xfer_pkg::*;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic enable_r;
    logic go;
    logic dec_display;
    logic dec_store;
    logic dec_clock;
    logic dec_tbit;
    logic [3:0] imm_j;
    logic [15:0] count_r;

    assign go = instr_valid && enable_r;
    assign dec_display = go && (instr == OP_LOAD_DISPLAY_TIMER);
    assign dec_clock = go && (instr == OP_LOAD_CLOCK_CTRL);
    assign dec_tbit = go && (instr == OP_LOAD_TIMER_CTRL_BIT);
    assign dec_store = go && (instr[9:4] == OP_STORE_FLIP_HI);
    assign imm_j = instr[STORE_FLIP_J_LSB +: 4];

    // ----------------------------------------
    // Timer and clock registers
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            display_timer <= RST_NIBBLE;
            display_timer_reload <= RST_NIBBLE;
        end else if (dec_display) begin
            display_timer <= acc;
            display_timer_reload <= acc;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clock_control_reg <= RST_NIBBLE;
        end else if (dec_clock) begin
            clock_control_reg <= acc;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer_ctrl_bit <= 1'b0;
        end else if (dec_tbit) begin
            timer_ctrl_bit <= acc[0];
        end
    end

    // ----------------------------------------
    // Store and flip
    // ----------------------------------------
    // The RAM address is built from the file register before the flip, so the
    // write lands in the current file and the new file applies from the next word.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ram_we <= 1'b0;
            ram_addr <= '0;
            ram_wdata <= RST_NIBBLE;
        end else begin
            ram_we <= dec_store;
            if (dec_store) begin
                ram_addr <= {file_reg, data_pointer};
                ram_wdata <= acc;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            file_reg <= RST_NIBBLE;
        end else if (dec_store) begin
            file_reg <= file_reg ^ imm_j;
        end
    end

    // ----------------------------------------
    // Completion and flags
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
            carry_we <= 1'b0;
            skip_next <= 1'b0;
            count_r <= '0;
        end else begin
            done <= dec_display || dec_store || dec_clock || dec_tbit;
            carry_we <= 1'b0;
            skip_next <= 1'b0;
            if (dec_display || dec_store || dec_clock || dec_tbit) begin
                count_r <= count_r + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    // One wait state per access keeps read data registered at a small latency cost.
    logic req;
    logic [31:0] status_word;

    assign req = avs_read || avs_write;

    always_comb begin
        status_word = '0;
        status_word[ST_FILE_LSB +: 4] = file_reg;
        status_word[ST_CLOCK_LSB +: 4] = clock_control_reg;
        status_word[ST_TIMER_BIT] = timer_ctrl_bit;
        status_word[ST_DISPLAY_LSB +: 4] = display_timer;
        status_word[ST_RELOAD_LSB +: 4] = display_timer_reload;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
        end else if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            case (avs_address)
                OFS_STATUS: avs_readdata <= status_word;
                OFS_CTRL: avs_readdata <= {31'h0000_0000, enable_r};
                OFS_COUNT: avs_readdata <= {16'h0000, count_r};
                default: avs_readdata <= '0;
            endcase
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= RST_ENABLE;
        end else if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL) begin
            enable_r <= avs_writedata[CTRL_ENABLE_BIT];
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_display_pair_load: assert property (
        @(posedge mclk) disable iff (!rst_n)
        dec_display |=> (display_timer == $past(acc)) && (display_timer_reload == $past(acc)))
        else $error("Display timer pair not loaded from accumulator.");

    a_ram_store_data: assert property (
        @(posedge mclk) disable iff (!rst_n)
        dec_store |=> ram_we && ram_wdata == $past(acc)
            && ram_addr == {$past(file_reg), $past(data_pointer)})
        else $error("Store did not write accumulator at the data pointer.");

    a_file_flip_xor: assert property (
        @(posedge mclk) disable iff (!rst_n)
        dec_store |=> file_reg == ($past(file_reg) ^ $past(imm_j)))
        else $error("File register not flipped by the immediate.");

    a_file_held_else: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !dec_store |=> $stable(file_reg))
        else $error("File register changed without a store.");

    a_clock_ctrl_load: assert property (
        @(posedge mclk) disable iff (!rst_n)
        dec_clock |=> clock_control_reg == $past(acc))
        else $error("Clock control not loaded from accumulator.");

    a_timer_bit_only: assert property (
        @(posedge mclk) disable iff (!rst_n)
        dec_tbit |=> timer_ctrl_bit == $past(acc[0]) && $stable(clock_control_reg))
        else $error("Timer control bit load wrong.");

    a_one_cycle_done: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (dec_display || dec_store || dec_clock || dec_tbit) |=> done
            ##1 (!done || $past(dec_display || dec_store || dec_clock || dec_tbit)))
        else $error("Instruction did not complete in one cycle.");

    a_no_flag_effect: assert property (
        @(posedge mclk) disable iff (!rst_n)
        done |-> !carry_we && !skip_next)
        else $error("Transfer touched carry or skip.");

    a_bus_one_wait: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("Bus answer not given after one wait state.");
endmodule : accumulator_transfer_decode
`default_nettype wire

// File: tb/ram_model.sv
// Data RAM model on the far side of the decoder's write port.
`timescale 1ns/10ps
`default_nettype none
module ram_model #(
    parameter int AW = 8
) (
    // Clock
    input wire logic mclk,
    // Write port
    input wire logic ram_we,
    input wire logic [AW-1:0] ram_addr,
    input wire logic [3:0] ram_wdata
);
    logic [3:0] mem [2**AW];
    initial begin
        foreach (mem[i]) mem[i] = 4'h0;
    end
    // A write lands on the edge that sees the strobe, as a synchronous RAM would.
    always @(posedge mclk) begin
        if (ram_we === 1'b1) begin
            mem[ram_addr] <= ram_wdata;
        end
    end
endmodule : ram_model
`default_nettype wire

// File: tb/accumulator_transfer_decode_tb.sv
// Self-checking bench for the accumulator transfer decoder.
`timescale 1ns/10ps
`default_nettype none
module accumulator_transfer_decode_tb;
    import xfer_pkg::*;
    logic mclk, rst_n, instr_valid, avs_read, avs_write, en, x_tb;
    logic ram_we, timer_ctrl_bit, done, carry_we, skip_next, avs_waitrequest;
    logic [9:0] instr;
    logic [3:0] acc, data_pointer, avs_address, ram_wdata, file_reg, display_timer;
    logic [3:0] display_timer_reload, clock_control_reg, x_f, x_dt, x_dr, x_cc, x_wd;
    logic [7:0] ram_addr, x_addr;
    logic [15:0] x_cnt;
    logic [31:0] avs_writedata, avs_readdata, rd, seed;
    logic [29:0] notes[$];
    int err_count, num_checks;
    accumulator_transfer_decode dut (.mclk, .rst_n, .instr_valid, .instr, .acc, .data_pointer,
        .ram_we, .ram_addr, .ram_wdata, .file_reg, .display_timer, .display_timer_reload,
        .clock_control_reg, .timer_ctrl_bit, .done, .carry_we, .skip_next, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    ram_model u_ram (.mclk, .ram_we, .ram_addr, .ram_wdata);
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [31:0] st();
        return {12'h000, x_dr, x_dt, 3'b000, x_tb, x_cc, x_f};
    endfunction : st
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic finish_test();
        check("pending", 32'h0000_0000, notes.size());
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    // The master holds everything until waitrequest is seen low, then idles one cycle.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task automatic model(input logic [9:0] w, input logic [3:0] a, input logic [3:0] dp);
        logic we;
        we = 1'b0;
        if (w == OP_LOAD_DISPLAY_TIMER) begin
            x_dt = a;
            x_dr = a;
        end else if (w == OP_LOAD_CLOCK_CTRL) begin
            x_cc = a;
        end else if (w == OP_LOAD_TIMER_CTRL_BIT) begin
            x_tb = a[0];
        end else if (w[9:4] == OP_STORE_FLIP_HI) begin
            we = 1'b1;
            x_addr = {x_f, dp};
            x_wd = a;
            x_f = x_f ^ w[3:0];
        end else begin
            return;
        end
        x_cnt++;
        notes.push_back({x_f, x_dt, x_dr, x_cc, x_tb, we, x_addr, x_wd});
    endtask : model
    // Random words mix all four transfers with unmatched opcodes, back to back.
    task automatic issue(input int n);
        logic [9:0] w;
        repeat (n) begin
            seed = xs(seed);
            w = seed[2:0] == 3'd0 ? OP_LOAD_DISPLAY_TIMER : seed[2:0] == 3'd1 ? OP_LOAD_CLOCK_CTRL
                : seed[2:0] == 3'd2 ? OP_LOAD_TIMER_CTRL_BIT
                : seed[2] ? {OP_STORE_FLIP_HI, seed[7:4]} : seed[17:8];
            instr_valid <= 1'b1;
            instr <= w;
            acc <= seed[23:20];
            data_pointer <= seed[27:24];
            if (en) model(w, seed[23:20], seed[27:24]);
            @(posedge mclk);
        end
        instr_valid <= 1'b0;
    endtask : issue
    always @(posedge mclk) begin
        if (rst_n) begin
            check("carry_skip", 32'h0000_0000, {carry_we, skip_next});
            if (done === 1'b1 && notes.size() == 0) begin
                check("done", 32'h0000_0000, 32'h0000_0001);
            end else if (done === 1'b1) begin
                check("state", notes.pop_front(), {file_reg, display_timer, display_timer_reload,
                    clock_control_reg, timer_ctrl_bit, ram_we, ram_addr, ram_wdata});
            end
        end
    end
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        finish_test();
    end
    initial begin
        {rst_n, instr_valid, avs_read, avs_write, instr, acc, data_pointer} = '0;
        {avs_address, avs_writedata, x_f, x_dt, x_dr, x_cc, x_wd, x_addr, x_tb, x_cnt} = '0;
        {err_count, num_checks, en, seed} = {32'd0, 32'd0, 1'b1, 32'h0000_1136};
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        bus(1'b0, OFS_CTRL, 32'h0000_0000);
        check("ctrl", 32'h0000_0001, rd);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        check("status", st(), rd);
        issue(200);
        repeat (3) @(posedge mclk);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        check("status", st(), rd);
        bus(1'b0, OFS_COUNT, 32'h0000_0000);
        check("count", {16'h0000, x_cnt}, rd);
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        en = 1'b0;
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        bus(1'b0, 4'hC, 32'h0000_0000);
        check("unmapped", 32'h0000_0000, rd);
        issue(40);
        repeat (3) @(posedge mclk);
        bus(1'b0, OFS_COUNT, 32'h0000_0000);
        check("count", {16'h0000, x_cnt}, rd);
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        en = 1'b1;
        issue(30);
        repeat (3) @(posedge mclk);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        check("status", st(), rd);
        check("ram", {28'h000_0000, x_wd}, {28'h000_0000, u_ram.mem[x_addr]});
        finish_test();
    end
endmodule : accumulator_transfer_decode_tb
`default_nettype wire
